// File: ccr_cfg.svh
// Offsets, field positions, reset values and scale constants of the charger configuration bank
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

`define CCR_OFS_PRECHARGE_TERM_CURRENT 8'h03
`define CCR_OFS_CHARGE_VOLTAGE_CONTROL 8'h04
`define CCR_OFS_TERMINATION_TIMER_CONTROL 8'h05
`define CCR_OFS_THERMAL_REGULATION_CONTROL 8'h06

`define CCR_RST_PRECHARGE_TERM_CURRENT 8'h11
`define CCR_RST_CHARGE_VOLTAGE_CONTROL 8'hCA
`define CCR_RST_TERMINATION_TIMER_CONTROL 8'h9A
`define CCR_RST_THERMAL_REGULATION_CONTROL 8'h03

`define CCR_PRECHG_MSB 7
`define CCR_PRECHG_LSB 4
`define CCR_TERMINATION_CURRENT_LIMIT_MSB 3
`define CCR_TERMINATION_CURRENT_LIMIT_LSB 0
`define CCR_VLIM_MSB 7
`define CCR_VLIM_LSB 2
`define CCR_FAST_THR_BIT 1
`define CCR_RECHG_BIT 0
`define CCR_TERM_EN_BIT 7
`define CCR_TERM_IND_BIT 6
`define CCR_WDOG_MSB 5
`define CCR_WDOG_LSB 4
`define CCR_TIMER_EN_BIT 3
`define CCR_TLIM_MSB 2
`define CCR_TLIM_LSB 1
`define CCR_THERMAL_REGULATION_THRESHOLD_MSB 1
`define CCR_THERMAL_REGULATION_THRESHOLD_LSB 0

`define CCR_CUR_OFS_MA 12'h080
`define CCR_CUR_STEP_MA 12'h080
`define CCR_VLIM_OFS_MV 13'h0DB0
`define CCR_VLIM_STEP_MV 13'h0010
`define CCR_VLIM_TOP_CODE 6'h38
`define CCR_FAST_THR_LO_MV 12'hAF0
`define CCR_FAST_THR_HI_MV 12'hBB8
`define CCR_RECHG_LO_MV 13'h0064
`define CCR_RECHG_HI_MV 13'h012C
`define CCR_WDOG_40_S 8'h28
`define CCR_WDOG_80_S 8'h50
`define CCR_WDOG_160_S 8'hA0
`define CCR_TLIM_5_H 5'h05
`define CCR_TLIM_8_H 5'h08
`define CCR_TLIM_12_H 5'h0C
`define CCR_TLIM_20_H 5'h14
`define CCR_THERMAL_REGULATION_THRESHOLD_60_C 7'h3C
`define CCR_THERMAL_REGULATION_THRESHOLD_80_C 7'h50
`define CCR_THERMAL_REGULATION_THRESHOLD_100_C 7'h64
`define CCR_THERMAL_REGULATION_THRESHOLD_120_C 7'h78

`endif

// File: ccr_pkg.sv
// Types shared by the charger configuration bank
`default_nettype none
package ccr_pkg;

    typedef enum {
        CCR_SEL_NONE,
        CCR_SEL_PRECHARGE_TERM,
        CCR_SEL_CHARGE_VOLTAGE,
        CCR_SEL_TERM_TIMER,
        CCR_SEL_THERMAL
    } ccr_sel_e;

    typedef struct packed {
        logic [3:0] precharge_current_limit;
        logic [3:0] termination_current_limit;
        logic [5:0] charge_voltage_limit;
        logic precharge_fast_threshold;
        logic recharge_offset;
        logic term_enable;
        logic term_indicator_early;
        logic [1:0] watchdog_period;
        logic safety_timer_enable;
        logic [1:0] fast_charge_time_limit;
        logic [1:0] thermal_regulation_threshold;
    } ccr_ctrl_s;

    typedef struct packed {
        logic [11:0] precharge_ma;
        logic [11:0] precharge_applied_ma;
        logic [11:0] termination_ma;
        logic [12:0] charge_voltage_mv;
        logic [12:0] recharge_mv;
        logic [11:0] fast_threshold_mv;
        logic [7:0] watchdog_s;
        logic [4:0] time_limit_hrs;
        logic [6:0] thermal_degc;
    } ccr_phys_s;

endpackage

`default_nettype wire

// File: ccr_cfg_reg.sv
// One 8-bit read/write configuration register with a constant reset value
`timescale 1ns/10ps
`default_nettype none

module ccr_cfg_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] q
);

    logic [7:0] val_d;
    logic [7:0] val_q;

    // Whole byte stored, reserved bits included, so reads return what was written
    always_comb begin
        val_d = val_q;
        if (wr_en) begin
            val_d = wr_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            val_q <= RST_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign q = val_q;

endmodule // ccr_cfg_reg

`default_nettype wire

// File: ccr_config_bank.sv
// Charger configuration register bank: four host registers and their control outputs
`timescale 1ns/10ps
`default_nettype none
`include "ccr_cfg.svh"

module ccr_config_bank (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic FORCE_REDUCED_CURRENT,
    input wire logic TERM_CURRENT_MATCH,
    input wire logic CHG_CURRENT_BELOW_800MA,
    output ccr_pkg::ccr_ctrl_s CTRL,
    output ccr_pkg::ccr_phys_s PHYS,
    output logic CHARGE_DONE_IND
);
    import ccr_pkg::*;

    ccr_sel_e sel;
    logic [7:0] prechg_term_q;
    logic [7:0] chg_volt_q;
    logic [7:0] term_timer_q;
    logic [7:0] thermal_q;
    logic we_prechg_term;
    logic we_chg_volt;
    logic we_term_timer;
    logic we_thermal;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rvalid_d;
    logic rvalid_q;
    logic done_d;
    logic done_q;
    ccr_phys_s phys_d;
    ccr_phys_s phys_q;
    logic [11:0] prechg_ma;
    logic [12:0] vlim_mv;

    // Address decode
    always_comb begin
        case (REG_ADDR)
            `CCR_OFS_PRECHARGE_TERM_CURRENT: begin
                sel = CCR_SEL_PRECHARGE_TERM;
            end
            `CCR_OFS_CHARGE_VOLTAGE_CONTROL: begin
                sel = CCR_SEL_CHARGE_VOLTAGE;
            end
            `CCR_OFS_TERMINATION_TIMER_CONTROL: begin
                sel = CCR_SEL_TERM_TIMER;
            end
            `CCR_OFS_THERMAL_REGULATION_CONTROL: begin
                sel = CCR_SEL_THERMAL;
            end
            default: begin
                sel = CCR_SEL_NONE;
            end
        endcase
    end

    assign we_prechg_term = REG_WR && (sel == CCR_SEL_PRECHARGE_TERM);
    assign we_chg_volt = REG_WR && (sel == CCR_SEL_CHARGE_VOLTAGE);
    assign we_term_timer = REG_WR && (sel == CCR_SEL_TERM_TIMER);
    assign we_thermal = REG_WR && (sel == CCR_SEL_THERMAL);

    // Register storage
    ccr_cfg_reg #(
        .RST_VAL(`CCR_RST_PRECHARGE_TERM_CURRENT)
    ) u_prechg_term (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(we_prechg_term),
        .wr_data(REG_WDATA),
        .q(prechg_term_q)
    );

    ccr_cfg_reg #(
        .RST_VAL(`CCR_RST_CHARGE_VOLTAGE_CONTROL)
    ) u_chg_volt (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(we_chg_volt),
        .wr_data(REG_WDATA),
        .q(chg_volt_q)
    );

    ccr_cfg_reg #(
        .RST_VAL(`CCR_RST_TERMINATION_TIMER_CONTROL)
    ) u_term_timer (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(we_term_timer),
        .wr_data(REG_WDATA),
        .q(term_timer_q)
    );

    ccr_cfg_reg #(
        .RST_VAL(`CCR_RST_THERMAL_REGULATION_CONTROL)
    ) u_thermal (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(we_thermal),
        .wr_data(REG_WDATA),
        .q(thermal_q)
    );

    // Raw field outputs, no transformation
    always_comb begin
        CTRL.precharge_current_limit = prechg_term_q[`CCR_PRECHG_MSB:`CCR_PRECHG_LSB];
        CTRL.termination_current_limit = prechg_term_q[`CCR_TERMINATION_CURRENT_LIMIT_MSB:`CCR_TERMINATION_CURRENT_LIMIT_LSB];
        CTRL.charge_voltage_limit = chg_volt_q[`CCR_VLIM_MSB:`CCR_VLIM_LSB];
        CTRL.precharge_fast_threshold = chg_volt_q[`CCR_FAST_THR_BIT];
        CTRL.recharge_offset = chg_volt_q[`CCR_RECHG_BIT];
        CTRL.term_enable = term_timer_q[`CCR_TERM_EN_BIT];
        CTRL.term_indicator_early = term_timer_q[`CCR_TERM_IND_BIT];
        CTRL.watchdog_period = term_timer_q[`CCR_WDOG_MSB:`CCR_WDOG_LSB];
        CTRL.safety_timer_enable = term_timer_q[`CCR_TIMER_EN_BIT];
        CTRL.fast_charge_time_limit = term_timer_q[`CCR_TLIM_MSB:`CCR_TLIM_LSB];
        CTRL.thermal_regulation_threshold = thermal_q[`CCR_THERMAL_REGULATION_THRESHOLD_MSB:`CCR_THERMAL_REGULATION_THRESHOLD_LSB];
    end

    // Read data, unmapped offsets read as zero
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = REG_RD;
        if (REG_RD) begin
            case (sel)
                CCR_SEL_PRECHARGE_TERM: begin
                    rdata_d = prechg_term_q;
                end
                CCR_SEL_CHARGE_VOLTAGE: begin
                    rdata_d = chg_volt_q;
                end
                CCR_SEL_TERM_TIMER: begin
                    rdata_d = term_timer_q;
                end
                CCR_SEL_THERMAL: begin
                    rdata_d = thermal_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // Charge indicator
    always_comb begin
        if (CTRL.term_indicator_early) begin
            done_d = TERM_CURRENT_MATCH || CHG_CURRENT_BELOW_800MA;
        end else begin
            done_d = TERM_CURRENT_MATCH;
        end
    end

    // Decoded physical values
    always_comb begin
        prechg_ma = 12'(`CCR_CUR_OFS_MA
            + `CCR_CUR_STEP_MA * {8'h00, CTRL.precharge_current_limit});
        phys_d.precharge_ma = prechg_ma;
        if (FORCE_REDUCED_CURRENT) begin
            phys_d.precharge_applied_ma = {1'b0, prechg_ma[11:1]};
        end else begin
            phys_d.precharge_applied_ma = prechg_ma;
        end
        phys_d.termination_ma = 12'(`CCR_CUR_OFS_MA
            + `CCR_CUR_STEP_MA * {8'h00, CTRL.termination_current_limit});
        if (CTRL.charge_voltage_limit > `CCR_VLIM_TOP_CODE) begin
            vlim_mv = 13'(`CCR_VLIM_OFS_MV
                + `CCR_VLIM_STEP_MV * {7'h00, `CCR_VLIM_TOP_CODE});
        end else begin
            vlim_mv = 13'(`CCR_VLIM_OFS_MV
                + `CCR_VLIM_STEP_MV * {7'h00, CTRL.charge_voltage_limit});
        end
        phys_d.charge_voltage_mv = vlim_mv;
        if (CTRL.recharge_offset) begin
            phys_d.recharge_mv = 13'(vlim_mv - `CCR_RECHG_HI_MV);
        end else begin
            phys_d.recharge_mv = 13'(vlim_mv - `CCR_RECHG_LO_MV);
        end
        if (CTRL.precharge_fast_threshold) begin
            phys_d.fast_threshold_mv = `CCR_FAST_THR_HI_MV;
        end else begin
            phys_d.fast_threshold_mv = `CCR_FAST_THR_LO_MV;
        end
        case (CTRL.watchdog_period)
            2'h1: begin
                phys_d.watchdog_s = `CCR_WDOG_40_S;
            end
            2'h2: begin
                phys_d.watchdog_s = `CCR_WDOG_80_S;
            end
            2'h3: begin
                phys_d.watchdog_s = `CCR_WDOG_160_S;
            end
            default: begin
                phys_d.watchdog_s = 8'h00;
            end
        endcase
        case (CTRL.fast_charge_time_limit)
            2'h0: begin
                phys_d.time_limit_hrs = `CCR_TLIM_5_H;
            end
            2'h1: begin
                phys_d.time_limit_hrs = `CCR_TLIM_8_H;
            end
            2'h2: begin
                phys_d.time_limit_hrs = `CCR_TLIM_12_H;
            end
            default: begin
                phys_d.time_limit_hrs = `CCR_TLIM_20_H;
            end
        endcase
        case (CTRL.thermal_regulation_threshold)
            2'h0: begin
                phys_d.thermal_degc = `CCR_THERMAL_REGULATION_THRESHOLD_60_C;
            end
            2'h1: begin
                phys_d.thermal_degc = `CCR_THERMAL_REGULATION_THRESHOLD_80_C;
            end
            2'h2: begin
                phys_d.thermal_degc = `CCR_THERMAL_REGULATION_THRESHOLD_100_C;
            end
            default: begin
                phys_d.thermal_degc = `CCR_THERMAL_REGULATION_THRESHOLD_120_C;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            done_q <= 1'b0;
            phys_q <= '0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            done_q <= done_d;
            phys_q <= phys_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign CHARGE_DONE_IND = done_q;
    assign PHYS = phys_q;

endmodule // ccr_config_bank

`default_nettype wire

// File: ccr_config_bank_chk.sv
// Assertion checker for the charger configuration bank
`timescale 1ns/10ps
`default_nettype none
module ccr_config_bank_chk (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic FORCE_REDUCED_CURRENT,
    input wire logic TERM_CURRENT_MATCH,
    input wire logic CHG_CURRENT_BELOW_800MA,
    input wire ccr_pkg::ccr_ctrl_s CTRL,
    input wire ccr_pkg::ccr_phys_s PHYS,
    input wire logic CHARGE_DONE_IND
);
    import ccr_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    sequence s_wr(logic [7:0] a);
        REG_WR && REG_ADDR == a;
    endsequence
    sequence s_done_cause;
        TERM_CURRENT_MATCH || (CTRL.term_indicator_early && CHG_CURRENT_BELOW_800MA);
    endsequence
    // Start only once reset is seen released, so the reset-cleared decode is not judged
    sequence s_thr_set;
        NRST && CTRL.precharge_fast_threshold ##1 1'b1;
    endsequence
    AST_RD_VALID: assert property (REG_RD |=> REG_RVALID) else $error("read unanswered");
    AST_NO_RD: assert property (!REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
        else $error("read data moved without a read");
    AST_CUR: assert property (s_wr(8'h03) |=> CTRL[24:17] == $past(REG_WDATA))
        else $error("current fields not written");
    AST_VLIM: assert property (s_wr(8'h04) |=> CTRL[16:9] == $past(REG_WDATA))
        else $error("voltage fields not written");
    AST_TT: assert property (s_wr(8'h05) |=> CTRL[8:2] == $past(REG_WDATA[7:1]))
        else $error("termination timer fields not written");
    AST_THERMAL_REGULATION_THRESHOLD: assert property (s_wr(8'h06) |=> CTRL[1:0] == $past(REG_WDATA[1:0]))
        else $error("thermal field not written");
    AST_HOLD: assert property (!REG_WR |=> $stable(CTRL)) else $error("control moved");
    AST_DONE_HI: assert property (s_done_cause |=> CHARGE_DONE_IND)
        else $error("indicator missed");
    AST_DONE_LO: assert property (!TERM_CURRENT_MATCH &&
        !(CTRL.term_indicator_early && CHG_CURRENT_BELOW_800MA) |=> !CHARGE_DONE_IND)
        else $error("indicator early");
    AST_HALF: assert property (PHYS.precharge_applied_ma ==
        ($past(FORCE_REDUCED_CURRENT) ? PHYS.precharge_ma >> 1 : PHYS.precharge_ma))
        else $error("applied precharge wrong");
    AST_THR: assert property (s_thr_set |-> PHYS.fast_threshold_mv == 12'hBB8)
        else $error("threshold wrong");
    AST_UNMAP: assert property (REG_RD && !(REG_ADDR inside {[8'h03:8'h06]})
        |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
endmodule // ccr_config_bank_chk
bind ccr_config_bank ccr_config_bank_chk u_ccr_config_bank_chk (
    .CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .FORCE_REDUCED_CURRENT(FORCE_REDUCED_CURRENT),
    .TERM_CURRENT_MATCH(TERM_CURRENT_MATCH), .CHG_CURRENT_BELOW_800MA(CHG_CURRENT_BELOW_800MA),
    .CTRL(CTRL), .PHYS(PHYS), .CHARGE_DONE_IND(CHARGE_DONE_IND)
);
`default_nettype wire

// File: ccr_host_model.sv
// Host side model issuing register writes and reads
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic wr,
    output logic [7:0] wdata,
    output logic rd,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        wdata = 8'h00;
        rd = 1'b0;
    end
    function automatic logic [7:0] rsv_mask(input logic [7:0] a);
        return (a == 8'h05) ? 8'hFE : (a == 8'h06) ? 8'h03 : 8'hFF;
    endfunction
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d & rsv_mask(a);
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~wdata;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        v = rvalid;
    endtask
endmodule // ccr_host_model
`default_nettype wire

// File: ccr_config_bank_tb.sv
// Self-checking testbench of the charger configuration bank
`timescale 1ns/10ps
`default_nettype none
module ccr_config_bank_tb;
    import ccr_pkg::*;
    logic clk, nrst, wr, rd, rvalid, force_red, match, below, done, rd_v, exp_done;
    logic [7:0] addr, wdata, rdata, a, d, rd_d;
    logic [7:0] regs [2:7];
    ccr_ctrl_s ctrl;
    ccr_phys_s phys;
    int num_errors = 0;
    int check_count = 0;
    int seed = 41911;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ccr_host_model u_ccr_host_model (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata),
        .rd(rd), .rdata(rdata), .rvalid(rvalid));
    ccr_config_bank u_ccr_config_bank (.CLK(clk), .NRST(nrst), .REG_ADDR(addr),
        .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .FORCE_REDUCED_CURRENT(force_red), .TERM_CURRENT_MATCH(match),
        .CHG_CURRENT_BELOW_800MA(below), .CTRL(ctrl), .PHYS(phys), .CHARGE_DONE_IND(done));
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    function automatic ccr_ctrl_s exp_ctrl();
        return {regs[3], regs[4], regs[5][7:1], regs[6][1:0]};
    endfunction
    function automatic ccr_phys_s exp_phys(input logic f);
        ccr_phys_s p;
        logic [12:0] v;
        p.precharge_ma = 12'h080 + 12'h080 * regs[3][7:4];
        p.precharge_applied_ma = f ? p.precharge_ma >> 1 : p.precharge_ma;
        p.termination_ma = 12'h080 + 12'h080 * regs[3][3:0];
        v = 13'h0DB0 + 13'h0010 * regs[4][7:2];
        p.charge_voltage_mv = (v > 13'h1130) ? 13'h1130 : v;
        p.recharge_mv = p.charge_voltage_mv - (regs[4][0] ? 13'h012C : 13'h0064);
        p.fast_threshold_mv = regs[4][1] ? 12'hBB8 : 12'hAF0;
        p.watchdog_s = (regs[5][5:4] == 2'h0) ? 8'h00 : 8'h14 << regs[5][5:4];
        p.time_limit_hrs = 5'({5'h14, 5'h0C, 5'h08, 5'h05} >> (5 * regs[5][2:1]));
        p.thermal_degc = 7'h3C + 7'h14 * regs[6][1:0];
        return p;
    endfunction
    initial begin
        nrst = 1'b0;
        force_red = 1'b0;
        match = 1'b0;
        below = 1'b0;
        regs = '{8'h00, 8'h11, 8'hCA, 8'h9A, 8'h03, 8'h00};
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(ctrl, exp_ctrl());
        check(phys, exp_phys(force_red));
        for (int i = 2; i < 8; i++) begin
            u_ccr_host_model.read_reg(8'(i), rd_d, rd_v);
            check({rd_v, rd_d}, {1'b1, regs[i]});
        end
        for (int i = 0; i < 48; i++) begin
            a = (i < 8) ? 8'(3 + i % 4) : 8'(2 + {$random(seed)} % 6);
            d = (i < 4) ? 8'hFF : (i < 8) ? 8'hE4 : 8'($random(seed));
            @(posedge clk);
            force_red <= 1'($random(seed));
            u_ccr_host_model.write_reg(a, d);
            if (a inside {[3:6]}) regs[a] = d & u_ccr_host_model.rsv_mask(a);
            u_ccr_host_model.read_reg(a, rd_d, rd_v);
            check({rd_v, rd_d}, {1'b1, regs[a]});
            check(ctrl, exp_ctrl());
            check(phys, exp_phys(force_red));
        end
        for (int j = 0; j < 2; j++) begin
            u_ccr_host_model.write_reg(8'h05, 8'h9A | 8'(j << 6));
            regs[5] = 8'h9A | 8'(j << 6);
            for (int i = 0; i < 100; i++) begin
                exp_done = match | (regs[5][6] & below);
                @(posedge clk);
                match <= 1'($random(seed));
                below <= 1'($random(seed));
                #1;
                check(done, exp_done);
            end
        end
        results();
    end
    initial begin
        #40000;
        num_errors++;
        results();
    end
endmodule // ccr_config_bank_tb
`default_nettype wire
